// ### pkg/ism_regs.svh
// Register offsets, field positions and timing constants of the snooping filter
`ifndef ISM_REGS_SVH
`define ISM_REGS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ISM_A_CTRL 8'h00
`define ISM_A_VLAN 8'h04
`define ISM_A_IMM 8'h08
`define ISM_A_QMODE 8'h0c
`define ISM_A_SGRP 8'h10
`define ISM_A_SCMD 8'h14
`define ISM_A_CCLR 8'h18
`define ISM_A_CQRY 8'h1c
`define ISM_A_CREP 8'h20
`define ISM_A_CLV 8'h24
`define ISM_A_CDROP 8'h28
`define ISM_A_QPORTS 8'h2c
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ISM_CTRL_GLOB 0
`define ISM_CTRL_SUP 1
`define ISM_CTRL_FIXED 2
`define ISM_CTRL_FLOOD 3
`define ISM_VLAN_EN 16
`define ISM_VLAN_UPD 31
`define ISM_SCMD_PORTS 16
`define ISM_SCMD_GO 31
// ----------------------------------------
// Codes, limits and counter slots
// ----------------------------------------
`define ISM_QM_AUTO 2'h0
`define ISM_QM_FIXED 2'h1
`define ISM_QM_EDGE 2'h2
`define ISM_VID_MAX 12'hffe
`define ISM_CNT_QRY 0
`define ISM_CNT_REP 1
`define ISM_CNT_LV 2
`define ISM_CNT_DROP 3
// ----------------------------------------
// Timing
// ----------------------------------------
`define ISM_AGE_S 64'd400
`define ISM_CLK_HZ 64'd250000000
`endif

// ### pkg/ism_pkg.sv
// Types shared by the snooping filter modules
package ism_pkg;
	// Kind of a parsed control packet
	typedef enum logic [1:0] {ISM_IG_QUERY, ISM_IG_REPORT, ISM_IG_LEAVE} ism_igmp_t;
	// Update operation on the group table
	typedef enum logic [2:0] {ISM_OP_NONE, ISM_OP_JOIN, ISM_OP_LEAVE, ISM_OP_STATIC, ISM_OP_QUERY} ism_op_t;
endpackage : ism_pkg

// ### hw/ism_group_table.sv
// Group membership table with one update port and one lookup port
`timescale 1ns/1ps
module ism_group_table #(
	parameter int NENT = 16,
	parameter int NPORT = 12
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Update port
	input wire ism_pkg::ism_op_t op_in,
	input wire logic [11:0] op_vlan_in,
	input wire logic [27:0] op_group_in,
	input wire logic [NPORT-1:0] op_ports_in,
	input wire logic flush_in,
	output logic op_hit_out,
	output logic op_rep_out,
	// Lookup port
	input wire logic [11:0] lk_vlan_in,
	input wire logic [27:0] lk_group_in,
	output logic lk_hit_out,
	output logic [NPORT-1:0] lk_ports_out
);
	import ism_pkg::*;
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic vld; // Entry in use
		logic stat; // Configured, immune to aging
		logic rep; // Report already passed this interval
		logic [11:0] vlan;
		logic [27:0] grp;
		logic [NPORT-1:0] ports; // Member ports
	} ism_ent_t;
	typedef struct packed {
		ism_ent_t [NENT-1:0] ent;
	} ism_tab_t;
	ism_tab_t st_r;
	ism_tab_t st_nxt;
	// ----------------------------------------
	// Search and update
	// ----------------------------------------
	always_comb begin : tab_comb
		int oi;
		int fi;
		oi = -1;
		fi = -1;
		st_nxt = st_r;
		op_hit_out = 1'b0;
		op_rep_out = 1'b0;
		lk_hit_out = 1'b0;
		lk_ports_out = '0;
		// Parallel compare of all entries
		for (int i = 0; i < NENT; i++) begin
			if (st_r.ent[i].vld && st_r.ent[i].vlan == op_vlan_in && st_r.ent[i].grp == op_group_in) begin
				oi = i;
			end
			if (!st_r.ent[i].vld) begin
				fi = i;
			end
			if (st_r.ent[i].vld && st_r.ent[i].vlan == lk_vlan_in && st_r.ent[i].grp == lk_group_in) begin
				lk_hit_out = 1'b1;
				lk_ports_out = st_r.ent[i].ports;
			end
		end
		if (oi >= 0) begin
			op_hit_out = 1'b1;
			op_rep_out = st_r.ent[oi].rep;
		end
		unique case (op_in)
			// Add member ports, allocate on miss; a full table drops the join
			ISM_OP_JOIN, ISM_OP_STATIC: begin
				if (oi >= 0) begin
					st_nxt.ent[oi].ports = st_r.ent[oi].ports | op_ports_in;
					st_nxt.ent[oi].rep = st_r.ent[oi].rep | (op_in == ISM_OP_JOIN);
					st_nxt.ent[oi].stat = st_r.ent[oi].stat | (op_in == ISM_OP_STATIC);
				end else if (fi >= 0) begin
					st_nxt.ent[fi].vld = 1'b1;
					st_nxt.ent[fi].stat = (op_in == ISM_OP_STATIC);
					st_nxt.ent[fi].rep = (op_in == ISM_OP_JOIN);
					st_nxt.ent[fi].vlan = op_vlan_in;
					st_nxt.ent[fi].grp = op_group_in;
					st_nxt.ent[fi].ports = op_ports_in;
				end
			end
			// Prune ports, free a learned entry left empty
			ISM_OP_LEAVE: begin
				if (oi >= 0) begin
					st_nxt.ent[oi].ports = st_r.ent[oi].ports & ~op_ports_in;
					if ((st_nxt.ent[oi].ports == '0) && !st_r.ent[oi].stat) begin
						st_nxt.ent[oi].vld = 1'b0;
					end
				end
			end
			// New query interval reopens report forwarding
			ISM_OP_QUERY: begin
				for (int i = 0; i < NENT; i++) begin
					st_nxt.ent[i].rep = 1'b0;
				end
			end
			ISM_OP_NONE: begin
			end
			default: begin
			end
		endcase
		// Aging flush removes learned entries only
		if (flush_in) begin
			for (int i = 0; i < NENT; i++) begin
				if (!st_nxt.ent[i].stat) begin
					st_nxt.ent[i].vld = 1'b0;
				end
			end
		end
	end
	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule : ism_group_table

// ### hw/ism_filter.sv
// Multicast membership learner and forwarding filter
// Contract
// - Learn group membership from snooped control packets
// - Forward group traffic only to member ports
// - Never create frames; only pass or drop
// - Hold snooping state for VLANs 1 to 4094
// - Auto mode enables VLANs seen carrying packets
// - Fixed mode learns only on added VLANs
// - Suppression passes first report per group interval
// - Snooping needs global enable, plus VLAN enable except for control packets in auto mode
// - Flush learned entries after 400 s idle
// - Reset disables global, VLAN and suppression enables
// - Unknown groups: drop or flood, configurable
// - Reset selects dropping unknown groups
// - Reset: immediate leave off, querier auto
// - Readable counters, all zeroed by clear
// - Immediate leave prunes port on leave
// - Edge ports never query ports; drop queries
// - Joins and leaves go to query ports
`timescale 1ns/1ps
`include "ism_regs.svh"
module ism_filter #(
	parameter int NPORT = 12,
	parameter int NENT = 16,
	parameter logic [39:0] AGE_CYC = 40'(`ISM_AGE_S * `ISM_CLK_HZ),
	localparam int PW = $clog2(NPORT)
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// Snooped control packet
	input wire logic ig_valid_in,
	input wire ism_pkg::ism_igmp_t ig_type_in,
	input wire logic [11:0] ig_vlan_in,
	input wire logic [27:0] ig_group_in,
	input wire logic [PW-1:0] ig_port_in,
	// Control packet decision
	output logic ig_fwd_valid_out,
	output logic [NPORT-1:0] ig_fwd_ports_out,
	output logic ig_drop_out,
	// Multicast data frame
	input wire logic mc_valid_in,
	input wire logic [11:0] mc_vlan_in,
	input wire logic [27:0] mc_group_in,
	input wire logic [PW-1:0] mc_port_in,
	// Data frame decision
	output logic mc_fwd_valid_out,
	output logic [NPORT-1:0] mc_fwd_ports_out
);
	import ism_pkg::*;
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic glob; // Global enable
		logic sup; // Report suppression
		logic fixed; // Fixed VLAN mode
		logic flood; // Flood unknown groups
		logic [4095:0] ven; // Per-VLAN enables
		logic [11:0] vsel; // VLAN shown on read
		logic [NPORT-1:0] imm; // Immediate leave per port
		logic [2*NPORT-1:0] qm; // Querier mode per port
		logic [NPORT-1:0] qseen; // Auto ports that got queries
		logic [39:0] age; // Idle timer
		logic [3:0][15:0] cnt; // Statistics
		logic [27:0] sgrp; // Configured group address
		logic [11:0] svlan; // Configured group VLAN
		logic [NPORT-1:0] sports; // Configured group ports
		logic spend; // Configured group waiting for table
		logic [31:0] rdata;
		logic igv;
		logic [NPORT-1:0] igp;
		logic igd;
		logic mcv;
		logic [NPORT-1:0] mcp;
	} ism_st_t;
	ism_st_t st_r;
	ism_st_t st_nxt;
	// Table update request
	ism_op_t tab_op;
	logic [11:0] tab_vlan;
	logic [27:0] tab_grp;
	logic [NPORT-1:0] tab_ports;
	logic tab_flush;
	// Table answers
	logic tab_hit;
	logic tab_rep;
	logic lk_hit;
	logic [NPORT-1:0] lk_ports;
	// Per-port querier decode
	logic [NPORT-1:0] qport;
	logic [NPORT-1:0] qedge;
	logic [NPORT-1:0] qauto;
	// Decoded source ports and snoop state
	logic [NPORT-1:0] ig_src;
	logic [NPORT-1:0] mc_src;
	logic ig_on;
	logic mc_on;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// VLAN identifier inside the snoopable range
	function automatic logic vid_ok(input logic [11:0] vid);
		return (vid != 12'h000) && (vid <= `ISM_VID_MAX);
	endfunction : vid_ok
	// Port number to one-hot mask
	function automatic logic [NPORT-1:0] onehot(input logic [PW-1:0] p);
		return {{(NPORT-1){1'b0}}, 1'b1} << p;
	endfunction : onehot
	// ----------------------------------------
	// Querier mode decode
	// ----------------------------------------
	for (genvar i = 0; i < NPORT; i++) begin : g_qm
		// Fixed always, auto after a query, edge never
		assign qport[i] = (st_r.qm[2*i+:2] == `ISM_QM_FIXED) || (qauto[i] && st_r.qseen[i]);
		assign qedge[i] = (st_r.qm[2*i+:2] == `ISM_QM_EDGE);
		assign qauto[i] = (st_r.qm[2*i+:2] == `ISM_QM_AUTO);
	end
	// Source decode and effective snoop state
	assign ig_src = onehot(ig_port_in);
	assign mc_src = onehot(mc_port_in);
	assign ig_on = st_r.glob && vid_ok(ig_vlan_in) && (st_r.ven[ig_vlan_in] || !st_r.fixed);
	assign mc_on = st_r.glob && vid_ok(mc_vlan_in) && st_r.ven[mc_vlan_in];
	// ----------------------------------------
	// Group table
	// ----------------------------------------
	ism_group_table #(
		.NENT(NENT),
		.NPORT(NPORT)
	) u_tab (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.op_in(tab_op),
		.op_vlan_in(tab_vlan),
		.op_group_in(tab_grp),
		.op_ports_in(tab_ports),
		.flush_in(tab_flush),
		.op_hit_out(tab_hit),
		.op_rep_out(tab_rep),
		.lk_vlan_in(mc_vlan_in),
		.lk_group_in(mc_group_in),
		.lk_hit_out(lk_hit),
		.lk_ports_out(lk_ports)
	);
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		tab_op = ISM_OP_NONE;
		tab_vlan = ig_vlan_in;
		tab_grp = ig_group_in;
		tab_ports = ig_src;
		tab_flush = 1'b0;
		// Idle timer, flush on expiry
		st_nxt.age = st_r.age + 40'd1;
		if ((st_r.age >= AGE_CYC - 40'd1) && !(ig_valid_in && ig_on)) begin
			tab_flush = 1'b1;
			st_nxt.age = '0;
		end
		// Register writes
		if (reg_wr_in) begin
			case (reg_addr_in)
				// Global switches
				`ISM_A_CTRL: begin
					st_nxt.glob = reg_wdata_in[`ISM_CTRL_GLOB];
					st_nxt.sup = reg_wdata_in[`ISM_CTRL_SUP];
					st_nxt.fixed = reg_wdata_in[`ISM_CTRL_FIXED];
					st_nxt.flood = reg_wdata_in[`ISM_CTRL_FLOOD];
				end
				// Select a VLAN, optionally set its enable
				`ISM_A_VLAN: begin
					st_nxt.vsel = reg_wdata_in[11:0];
					if (reg_wdata_in[`ISM_VLAN_UPD]) begin
						st_nxt.ven[reg_wdata_in[11:0]] = reg_wdata_in[`ISM_VLAN_EN];
					end
				end
				// Per-port settings
				`ISM_A_IMM: begin
					st_nxt.imm = reg_wdata_in[NPORT-1:0];
				end
				`ISM_A_QMODE: begin
					st_nxt.qm = reg_wdata_in[2*NPORT-1:0];
				end
				// Configured group entry
				`ISM_A_SGRP: begin
					st_nxt.sgrp = reg_wdata_in[27:0];
				end
				`ISM_A_SCMD: begin
					if (reg_wdata_in[`ISM_SCMD_GO]) begin
						st_nxt.svlan = reg_wdata_in[11:0];
						st_nxt.sports = reg_wdata_in[`ISM_SCMD_PORTS+:NPORT];
						st_nxt.spend = 1'b1;
					end
				end
				// Counter clear; later increments still land
				`ISM_A_CCLR: begin
					st_nxt.cnt = '0;
				end
				default: begin
				end
			endcase
		end
		// Control packet handling, decision only on input
		st_nxt.igv = ig_valid_in;
		st_nxt.igp = ~ig_src;
		st_nxt.igd = 1'b0;
		if (!ig_valid_in) begin
			st_nxt.igp = '0;
		end else if (ig_on) begin
			st_nxt.age = '0;
			if (!st_r.fixed && vid_ok(ig_vlan_in)) begin
				st_nxt.ven[ig_vlan_in] = 1'b1;
			end
			unique case (ig_type_in)
				// Query: drop on edge, else mark port and flood
				ISM_IG_QUERY: begin
					st_nxt.cnt[`ISM_CNT_QRY] = st_nxt.cnt[`ISM_CNT_QRY] + 16'h0001;
					if (qedge[ig_port_in]) begin
						st_nxt.igd = 1'b1;
						st_nxt.igp = '0;
						st_nxt.cnt[`ISM_CNT_DROP] = st_nxt.cnt[`ISM_CNT_DROP] + 16'h0001;
					end else begin
						st_nxt.qseen = st_r.qseen | (ig_src & qauto);
						tab_op = ISM_OP_QUERY;
					end
				end
				// Report: learn, pass to query ports; repeats in an interval dropped when suppression is on
				ISM_IG_REPORT: begin
					st_nxt.cnt[`ISM_CNT_REP] = st_nxt.cnt[`ISM_CNT_REP] + 16'h0001;
					tab_op = ISM_OP_JOIN;
					st_nxt.igp = qport & ~ig_src;
					if (st_r.sup && tab_hit && tab_rep) begin
						st_nxt.igd = 1'b1;
						st_nxt.igp = '0;
						st_nxt.cnt[`ISM_CNT_DROP] = st_nxt.cnt[`ISM_CNT_DROP] + 16'h0001;
					end
				end
				// Leave: pass to query ports, prune on fast-leave port
				ISM_IG_LEAVE: begin
					st_nxt.cnt[`ISM_CNT_LV] = st_nxt.cnt[`ISM_CNT_LV] + 16'h0001;
					st_nxt.igp = qport & ~ig_src;
					if (st_r.imm[ig_port_in]) begin
						tab_op = ISM_OP_LEAVE;
					end
				end
				default: begin
				end
			endcase
		end
		// Configured group enters when the table port is free
		if (st_r.spend && tab_op == ISM_OP_NONE) begin
			tab_op = ISM_OP_STATIC;
			tab_vlan = st_r.svlan;
			tab_grp = st_r.sgrp;
			tab_ports = st_r.sports;
			if (!(reg_wr_in && reg_addr_in == `ISM_A_SCMD && reg_wdata_in[`ISM_SCMD_GO])) begin
				st_nxt.spend = 1'b0;
			end
		end
		// Data frames: members, unknown policy, or plain flood
		st_nxt.mcv = mc_valid_in;
		st_nxt.mcp = '0;
		if (mc_valid_in) begin
			if (!mc_on) begin
				st_nxt.mcp = ~mc_src;
			end else if (lk_hit) begin
				st_nxt.mcp = lk_ports & ~mc_src;
			end else if (st_r.flood) begin
				st_nxt.mcp = ~mc_src;
			end
		end
		// Register reads, data valid next cycle only
		st_nxt.rdata = '0;
		if (reg_rd_in) begin
			case (reg_addr_in)
				`ISM_A_CTRL: st_nxt.rdata = {28'h0000000, st_r.flood, st_r.fixed, st_r.sup, st_r.glob};
				`ISM_A_VLAN: st_nxt.rdata = {15'h0000, st_r.ven[st_r.vsel], 4'h0, st_r.vsel};
				`ISM_A_IMM: st_nxt.rdata = 32'(st_r.imm);
				`ISM_A_QMODE: st_nxt.rdata = 32'(st_r.qm);
				`ISM_A_SGRP: st_nxt.rdata = {4'h0, st_r.sgrp};
				`ISM_A_SCMD: st_nxt.rdata = {st_r.spend, 31'h00000000};
				`ISM_A_CQRY: st_nxt.rdata = {16'h0000, st_r.cnt[`ISM_CNT_QRY]};
				`ISM_A_CREP: st_nxt.rdata = {16'h0000, st_r.cnt[`ISM_CNT_REP]};
				`ISM_A_CLV: st_nxt.rdata = {16'h0000, st_r.cnt[`ISM_CNT_LV]};
				`ISM_A_CDROP: st_nxt.rdata = {16'h0000, st_r.cnt[`ISM_CNT_DROP]};
				`ISM_A_QPORTS: st_nxt.rdata = 32'(qport);
				default: st_nxt.rdata = '0;
			endcase
		end
	end
	// ----------------------------------------
	// State register
	// ----------------------------------------
	// All-zero reset: enables off, drop unknown, fast leave off, querier auto
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata_out = st_r.rdata;
	assign ig_fwd_valid_out = st_r.igv;
	assign ig_fwd_ports_out = st_r.igp;
	assign ig_drop_out = st_r.igd;
	assign mc_fwd_valid_out = st_r.mcv;
	assign mc_fwd_ports_out = st_r.mcp;
endmodule : ism_filter

// ### sim/ism_host_model.sv
// Host and router model that emits parsed control packets
`timescale 1ns/1ps
module ism_host_model #(
	parameter int PW = 4
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Packet request
	input wire logic send_in,
	input wire ism_pkg::ism_igmp_t type_in,
	input wire logic [11:0] vlan_in,
	input wire logic [27:0] group_in,
	input wire logic [PW-1:0] port_in,
	// Packet toward the filter
	output logic ig_valid_out,
	output ism_pkg::ism_igmp_t ig_type_out,
	output logic [11:0] ig_vlan_out,
	output logic [27:0] ig_group_out,
	output logic [PW-1:0] ig_port_out
);
	import ism_pkg::*;
	// One packet per request; fields scramble while idle
	always_ff @(posedge sys_clk_in) begin
		ig_valid_out <= rst_n_in & send_in;
		ig_type_out <= send_in ? type_in : ism_igmp_t'(~ig_type_out);
		ig_vlan_out <= send_in ? vlan_in : ~ig_vlan_out;
		ig_group_out <= send_in ? group_in : ~ig_group_out;
		ig_port_out <= send_in ? port_in : ~ig_port_out;
	end
endmodule : ism_host_model

// ### sim/ism_filter_chk.sv
// Port-level checker of the snooping filter
`timescale 1ns/1ps
`include "ism_regs.svh"
module ism_filter_chk #(
	parameter int NPORT = 12,
	parameter int PW = 4
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	// Control packet path
	input wire logic ig_valid_in,
	input wire ism_pkg::ism_igmp_t ig_type_in,
	input wire logic [PW-1:0] ig_port_in,
	input wire logic ig_fwd_valid_out,
	input wire logic [NPORT-1:0] ig_fwd_ports_out,
	input wire logic ig_drop_out,
	// Data frame path
	input wire logic mc_valid_in,
	input wire logic [PW-1:0] mc_port_in,
	input wire logic mc_fwd_valid_out,
	input wire logic [NPORT-1:0] mc_fwd_ports_out
);
	import ism_pkg::*;
	// ----------------------------------------
	// Helper state
	// ----------------------------------------
	localparam logic [NPORT-1:0] ONE = NPORT'(1);
	logic glob_r; // Shadow of the global enable
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Track global enable writes
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) glob_r <= 1'b0;
		else if (reg_wr_in && reg_addr_in == `ISM_A_CTRL) glob_r <= reg_wdata_in[`ISM_CTRL_GLOB];
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	sequence s_off_mc;
		mc_valid_in && !glob_r;
	endsequence
	sequence s_off_ig;
		ig_valid_in && !glob_r;
	endsequence
	AST_GOFF: assert property (s_off_mc |=> mc_fwd_ports_out == ~(ONE << $past(mc_port_in)))
		else $error("data frame not flooded while snooping off");
	AST_IGOFF: assert property (s_off_ig |=> !ig_drop_out && ig_fwd_ports_out == ~(ONE << $past(ig_port_in)))
		else $error("control packet filtered while snooping off");
	AST_IGV: assert property (ig_fwd_valid_out == $past(ig_valid_in))
		else $error("control decision without matching packet");
	AST_MCV: assert property (mc_fwd_valid_out == $past(mc_valid_in))
		else $error("data decision without matching frame");
	AST_RD0: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
		else $error("read data outside read slot");
	AST_MCSRC: assert property (mc_fwd_valid_out |-> !mc_fwd_ports_out[$past(mc_port_in)])
		else $error("data frame sent back to source");
	AST_IGSRC: assert property (ig_fwd_valid_out |-> !ig_fwd_ports_out[$past(ig_port_in)])
		else $error("control packet sent back to source");
	AST_DROP0: assert property (ig_drop_out |-> ig_fwd_valid_out && ig_fwd_ports_out == '0)
		else $error("dropped packet still has egress ports");
	AST_DROPT: assert property (ig_valid_in && ig_type_in == ISM_IG_LEAVE |=> !ig_drop_out)
		else $error("leave packet dropped");
endmodule : ism_filter_chk
bind ism_filter ism_filter_chk #(.NPORT(NPORT), .PW(PW)) ism_filter_chk_i (.sys_clk_in, .rst_n_in,
	.reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .ig_valid_in, .ig_type_in,
	.ig_port_in, .ig_fwd_valid_out, .ig_fwd_ports_out, .ig_drop_out, .mc_valid_in, .mc_port_in,
	.mc_fwd_valid_out, .mc_fwd_ports_out);

// ### sim/testbench.sv
// Self-checking testbench of the snooping filter
`timescale 1ns/1ps
`include "ism_regs.svh"
module testbench;
	import ism_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic sys_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [31:0] reg_rdata_out;
	logic send = 1'b0; // Model request
	ism_igmp_t p_type = ISM_IG_QUERY;
	logic [11:0] p_vlan = 12'h0;
	logic [27:0] p_grp = 28'h0;
	logic [3:0] p_port = 4'h0;
	logic ig_valid;
	ism_igmp_t ig_type;
	logic [11:0] ig_vlan;
	logic [27:0] ig_group;
	logic [3:0] ig_port;
	logic ig_fwd_valid_out;
	logic [11:0] ig_fwd_ports_out;
	logic ig_drop_out;
	logic mc_valid_in = 1'b0;
	logic [11:0] mc_vlan_in = 12'h0;
	logic [27:0] mc_group_in = 28'h0;
	logic [3:0] mc_port_in = 4'h0;
	logic mc_fwd_valid_out;
	logic [11:0] mc_fwd_ports_out;
	// Clock at 250 MHz
	always #2 sys_clk_in = ~sys_clk_in;
	// ----------------------------------------
	// Instances
	// ----------------------------------------
	ism_host_model ism_host_model_i (.sys_clk_in, .rst_n_in, .send_in(send), .type_in(p_type),
		.vlan_in(p_vlan), .group_in(p_grp), .port_in(p_port), .ig_valid_out(ig_valid),
		.ig_type_out(ig_type), .ig_vlan_out(ig_vlan), .ig_group_out(ig_group), .ig_port_out(ig_port));
	ism_filter #(.AGE_CYC(40'd200)) ism_filter_i (.sys_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
		.reg_wr_in, .reg_rd_in, .reg_rdata_out, .ig_valid_in(ig_valid), .ig_type_in(ig_type),
		.ig_vlan_in(ig_vlan), .ig_group_in(ig_group), .ig_port_in(ig_port), .ig_fwd_valid_out,
		.ig_fwd_ports_out, .ig_drop_out, .mc_valid_in, .mc_vlan_in, .mc_group_in, .mc_port_in,
		.mc_fwd_valid_out, .mc_fwd_ports_out);
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	function automatic logic [11:0] nsrc(input int p);
		return ~(12'h1 << p);
	endfunction : nsrc
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1 chk(reg_rdata_out, e);
	endtask : rd
	// Packet via the model, decision two edges later
	task automatic ig(input ism_igmp_t t, input logic [11:0] v, input logic [27:0] g, input logic [3:0] p,
		input logic [11:0] ep, input logic ed);
		@(posedge sys_clk_in);
		send <= 1'b1;
		p_type <= t;
		p_vlan <= v;
		p_grp <= g;
		p_port <= p;
		@(posedge sys_clk_in);
		send <= 1'b0;
		@(posedge sys_clk_in);
		#1 chk(32'({ig_fwd_valid_out, ig_drop_out, ig_fwd_ports_out}), 32'({1'b1, ed, ep}));
	endtask : ig
	task automatic mc(input logic [11:0] v, input logic [27:0] g, input logic [3:0] p, input logic [11:0] e);
		@(posedge sys_clk_in);
		mc_valid_in <= 1'b1;
		mc_vlan_in <= v;
		mc_group_in <= g;
		mc_port_in <= p;
		@(posedge sys_clk_in);
		mc_valid_in <= 1'b0;
		#1 chk(32'({mc_fwd_valid_out, mc_fwd_ports_out}), 32'({1'b1, e}));
	endtask : mc
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(`ISM_A_CTRL, 32'h0);
		rd(`ISM_A_IMM, 32'h0);
		rd(`ISM_A_QMODE, 32'h0);
		wr(`ISM_A_VLAN, 32'h00000ffe);
		rd(`ISM_A_VLAN, 32'h00000ffe);
		for (int i = 0; i < 4; i++) rd(`ISM_A_CQRY + 8'(4 * i), 32'h0);
		rd(8'hfc, 32'h0);
	endtask : t_reset
	task automatic t_off();
		mc(12'h00a, 28'h1, 4'h2, nsrc(2));
		ig(ISM_IG_REPORT, 12'h00a, 28'h1, 4'h3, nsrc(3), 1'b0);
		rd(`ISM_A_CREP, 32'h0);
		wr(`ISM_A_VLAN, 32'h0000000a);
		rd(`ISM_A_VLAN, 32'h0000000a);
	endtask : t_off
	task automatic t_auto();
		wr(`ISM_A_CTRL, 32'h1);
		mc(12'h00a, 28'h1, 4'h2, nsrc(2));
		ig(ISM_IG_QUERY, 12'h00a, 28'h0, 4'h0, nsrc(0), 1'b0);
		ig(ISM_IG_REPORT, 12'h00a, 28'h1, 4'h3, 12'h001, 1'b0);
		mc(12'h00a, 28'h1, 4'h5, 12'h008);
		mc(12'h00a, 28'h2, 4'h5, 12'h000);
		rd(`ISM_A_VLAN, 32'h0001000a);
		rd(`ISM_A_QPORTS, 32'h1);
	endtask : t_auto
	task automatic t_sup();
		wr(`ISM_A_CTRL, 32'h3);
		ig(ISM_IG_REPORT, 12'h00a, 28'h1, 4'h4, 12'h000, 1'b1);
		ig(ISM_IG_QUERY, 12'h00a, 28'h0, 4'h0, nsrc(0), 1'b0);
		ig(ISM_IG_REPORT, 12'h00a, 28'h1, 4'h4, 12'h001, 1'b0);
	endtask : t_sup
	task automatic t_flood();
		wr(`ISM_A_CTRL, 32'h9);
		mc(12'h00a, 28'h2, 4'h5, nsrc(5));
		wr(`ISM_A_CTRL, 32'h1);
	endtask : t_flood
	task automatic t_edge();
		wr(`ISM_A_QMODE, 32'h6000);
		ig(ISM_IG_QUERY, 12'h00a, 28'h0, 4'h6, 12'h000, 1'b1);
		ig(ISM_IG_REPORT, 12'h00a, 28'h3, 4'h3, 12'h081, 1'b0);
	endtask : t_edge
	task automatic t_imm();
		wr(`ISM_A_IMM, 32'h008);
		ig(ISM_IG_LEAVE, 12'h00a, 28'h3, 4'h3, 12'h081, 1'b0);
		mc(12'h00a, 28'h3, 4'h5, 12'h000);
		ig(ISM_IG_LEAVE, 12'h00a, 28'h1, 4'h4, 12'h081, 1'b0);
		mc(12'h00a, 28'h1, 4'h5, 12'h018);
	endtask : t_imm
	task automatic t_fixed();
		wr(`ISM_A_CTRL, 32'h5);
		ig(ISM_IG_REPORT, 12'h014, 28'h4, 4'h3, nsrc(3), 1'b0);
		mc(12'h014, 28'h4, 4'h5, nsrc(5));
		wr(`ISM_A_VLAN, 32'h80010014);
		ig(ISM_IG_REPORT, 12'h014, 28'h4, 4'h3, 12'h081, 1'b0);
		mc(12'h014, 28'h4, 4'h5, 12'h008);
		wr(`ISM_A_VLAN, 32'h80010ffe);
		rd(`ISM_A_VLAN, 32'h00010ffe);
	endtask : t_fixed
	task automatic t_cnt();
		wr(`ISM_A_CCLR, 32'h1);
		for (int i = 0; i < 4; i++) rd(`ISM_A_CQRY + 8'(4 * i), 32'h0);
		ig(ISM_IG_QUERY, 12'h014, 28'h0, 4'h0, nsrc(0), 1'b0);
		ig(ISM_IG_QUERY, 12'h014, 28'h0, 4'h6, 12'h000, 1'b1);
		ig(ISM_IG_LEAVE, 12'h014, 28'h7, 4'h4, 12'h081, 1'b0);
		rd(`ISM_A_CQRY, 32'h2);
		rd(`ISM_A_CDROP, 32'h1);
		rd(`ISM_A_CLV, 32'h1);
	endtask : t_cnt
	task automatic t_age();
		// Configured group on port 5, must survive the aging flush
		wr(`ISM_A_SGRP, 32'h00000006);
		wr(`ISM_A_SCMD, 32'h80200014);
		rd(`ISM_A_SCMD, 32'h0);
		mc(12'h014, 28'h6, 4'h0, 12'h020);
		ig(ISM_IG_REPORT, 12'h014, 28'h5, 4'h3, 12'h081, 1'b0);
		repeat (150) @(posedge sys_clk_in);
		mc(12'h014, 28'h5, 4'h5, 12'h008);
		ig(ISM_IG_REPORT, 12'h014, 28'h5, 4'h4, 12'h081, 1'b0);
		repeat (150) @(posedge sys_clk_in);
		mc(12'h014, 28'h5, 4'h5, 12'h018);
		repeat (60) @(posedge sys_clk_in);
		mc(12'h014, 28'h5, 4'h5, 12'h000);
		mc(12'h014, 28'h6, 4'h0, 12'h020);
		rd(`ISM_A_CREP, 32'h2);
	endtask : t_age
	// ----------------------------------------
	// Sequence and verdict
	// ----------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : conclude
	// Cycle ceiling against hangs
	always @(posedge sys_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			conclude();
		end
	end
	// Main sequence
	initial begin
		repeat (10) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		t_reset();
		t_off();
		t_auto();
		t_sup();
		t_flood();
		t_edge();
		t_imm();
		t_fixed();
		t_cnt();
		t_age();
		conclude();
	end
endmodule : testbench
